/* verilog/prog_div_counter.sv */
// programmable divide-by-n down-counter with axi4-lite control
// How it works
// - output pulse once every n clocks
// - start count loaded from sixteen preset bits
// - first-section wrap decrements upper sections
// - divide-by-2 frees three flops for thousands
// - code 110 divides by ten, no last
// - three bcd decades preset from upper twelve
// - max modulus 9999 or 15999 per mode
// - decades accept binary preset up to fifteen
// - divide-by-8 first section presets up to seven
// - both hold inputs low: load and freeze
// - counting mode selected: count from loaded value
// - first edge after hold only arms
// - pulse due within one cycle, or two outside divide-by-2, still issued
// - without hold, reload presets at pulse
// - latch keeps output high, else one cycle
`timescale 1ns/10ps
module prog_div_counter
    import prog_div_pkg::*;
(
    input  wire logic                           mclk_i,
    input  wire logic                           rstn_i,
    input  wire logic [prog_div_pkg::ADDR_W-1:0] awaddr_i,
    input  wire logic                           awvalid_i,
    output logic                                awready_o,
    input  wire logic [31:0]                    wdata_i,
    input  wire logic [3:0]                     wstrb_i,
    input  wire logic                           wvalid_i,
    output logic                                wready_o,
    output logic [1:0]                          bresp_o,
    output logic                                bvalid_o,
    input  wire logic                           bready_i,
    input  wire logic [prog_div_pkg::ADDR_W-1:0] araddr_i,
    input  wire logic                           arvalid_i,
    output logic                                arready_o,
    output logic [31:0]                         rdata_o,
    output logic [1:0]                          rresp_o,
    output logic                                rvalid_o,
    input  wire logic                           rready_i,
    output logic                                div_out_o
);
    import prog_div_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction : merge_bytes

    // reload value of the first section: divisor minus one
    function automatic logic [3:0] first_top(input logic [2:0] mode);
        case (mode)
            MODE_DIV2:  first_top = 4'h1;
            MODE_DIV4:  first_top = 4'h3;
            MODE_DIV5:  first_top = 4'h4;
            MODE_DIV8:  first_top = 4'h7;
            MODE_DIV10: first_top = 4'h9;
            default:    first_top = 4'h0;
        endcase
    endfunction : first_top

    // low preset bits split between first and last section
    function automatic logic [3:0] first_preset(input logic [2:0] mode,
                                                input logic [3:0] p);
        case (mode)
            MODE_DIV2:  first_preset = {3'h0, p[0]};
            MODE_DIV4:  first_preset = {2'h0, p[1:0]};
            MODE_DIV5,
            MODE_DIV8:  first_preset = {1'b0, p[2:0]};
            default:    first_preset = p;
        endcase
    endfunction : first_preset

    function automatic logic [2:0] last_preset(input logic [2:0] mode,
                                               input logic [3:0] p);
        case (mode)
            MODE_DIV2:  last_preset = p[3:1];
            MODE_DIV4:  last_preset = {1'b0, p[3:2]};
            MODE_DIV5,
            MODE_DIV8:  last_preset = {2'h0, p[3]};
            default:    last_preset = 3'h0;
        endcase
    endfunction : last_preset

    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    logic [CTRL_W-1:0] ctrl_q;
    logic [15:0]       preset_q;
    logic              wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0]       wr_data;
    logic [3:0]        wr_strb;
    logic [ADDR_W-1:0] rd_addr;
    logic [31:0]       rd_data;
    logic              wr_ok;
    logic              rd_ok;
    logic [31:0]       ctrl_wr;
    logic [31:0]       preset_wr;
    logic [31:0]       status_w;

    prog_div_axil u_axil (
        .mclk_i    (mclk_i),
        .rstn_i    (rstn_i),
        .awaddr_i  (awaddr_i),
        .awvalid_i (awvalid_i),
        .awready_o (awready_o),
        .wdata_i   (wdata_i),
        .wstrb_i   (wstrb_i),
        .wvalid_i  (wvalid_i),
        .wready_o  (wready_o),
        .bresp_o   (bresp_o),
        .bvalid_o  (bvalid_o),
        .bready_i  (bready_i),
        .araddr_i  (araddr_i),
        .arvalid_i (arvalid_i),
        .arready_o (arready_o),
        .rdata_o   (rdata_o),
        .rresp_o   (rresp_o),
        .rvalid_o  (rvalid_o),
        .rready_i  (rready_i),
        .wr_en_o   (wr_en),
        .wr_addr_o (wr_addr),
        .wr_data_o (wr_data),
        .wr_strb_o (wr_strb),
        .wr_ok_i   (wr_ok),
        .rd_addr_o (rd_addr),
        .rd_data_i (rd_data),
        .rd_ok_i   (rd_ok)
    );

    assign wr_ok     = (wr_addr == CTRL_OFS) || (wr_addr == PRESET_OFS);
    assign rd_ok     = wr_ok_rd(rd_addr);
    assign ctrl_wr   = merge_bytes({{(32-CTRL_W){1'b0}}, ctrl_q}, wr_data, wr_strb);
    assign preset_wr = merge_bytes({16'h0000, preset_q}, wr_data, wr_strb);

    function automatic logic wr_ok_rd(input logic [ADDR_W-1:0] a);
        return (a == CTRL_OFS) || (a == PRESET_OFS) || (a == STATUS_OFS);
    endfunction : wr_ok_rd

    assign rd_data = (rd_addr == CTRL_OFS)   ? {{(32-CTRL_W){1'b0}}, ctrl_q} :
                     (rd_addr == PRESET_OFS) ? {16'h0000, preset_q} :
                     (rd_addr == STATUS_OFS) ? status_w : 32'h0000_0000;

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_q   <= CTRL_RST;
            preset_q <= PRESET_RST;
        end else if (wr_en && (wr_addr == CTRL_OFS)) begin
            ctrl_q   <= ctrl_wr[CTRL_W-1:0];
        end else if (wr_en && (wr_addr == PRESET_OFS)) begin
            preset_q <= preset_wr[15:0];
        end
    end

    // ------------------------------------------------------------
    // control decode
    // ------------------------------------------------------------
    logic [2:0] mode_sel;
    logic       hold_w;
    logic       latch_w;
    logic       mode_ok;
    logic [3:0] top_w;
    logic [3:0] first_pre_w;
    logic [2:0] last_pre_w;

    assign mode_sel    = ctrl_q[CTRL_MODE_LSB +: 3];
    assign hold_w      = !ctrl_q[CTRL_HOLD_LO] && !ctrl_q[CTRL_HOLD_HI];
    assign latch_w     = ctrl_q[CTRL_LATCH];
    assign top_w       = first_top(mode_sel);
    assign mode_ok     = (top_w != 4'h0);
    assign first_pre_w = first_preset(mode_sel, preset_q[3:0]);
    assign last_pre_w  = last_preset(mode_sel, preset_q[3:0]);

    // ------------------------------------------------------------
    // counter chain
    // ------------------------------------------------------------
    run_state_t state_q;
    run_state_t state_d;
    logic [3:0] first_q;
    logic [2:0] last_q;
    logic       due_q;
    logic       out_q;
    logic [3:0] dec_q    [DECADES];
    logic       dec_zero [DECADES];
    logic       dec_en   [DECADES+1];
    logic       upper_zero;
    logic       term_w;
    logic       run_w;
    logic       count_en;
    logic       load_w;
    logic       pulse_w;

    assign run_w      = (state_q == ST_RUN) && mode_ok;
    assign upper_zero = dec_zero[0] && dec_zero[1] && dec_zero[2] && (last_q == 3'h0);
    assign term_w     = run_w && upper_zero && (first_q == 4'h1);
    assign load_w     = hold_w || term_w;
    assign count_en   = run_w && !load_w;
    assign dec_en[0]  = count_en && (first_q == 4'h0);
    assign pulse_w    = term_w || due_q;

    generate
        for (genvar g = 0; g < DECADES; g++) begin : g_dec
            prog_div_decade u_dec (
                .mclk_i   (mclk_i),
                .rstn_i   (rstn_i),
                .load_i   (load_w),
                .preset_i (preset_q[4 + 4*g +: 4]),
                .dec_i    (dec_en[g]),
                .q_o      (dec_q[g]),
                .zero_o   (dec_zero[g])
            );
            assign dec_en[g+1] = dec_en[g] && dec_zero[g];
        end
    endgenerate

    // hold loads every cycle; leaving hold arms once before counting
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_HOLD: state_d = hold_w ? ST_HOLD : ST_ARM;
            ST_ARM:  state_d = hold_w ? ST_HOLD : ST_RUN;
            ST_RUN:  state_d = hold_w ? ST_HOLD : ST_RUN;
            default: state_d = ST_HOLD;
        endcase
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= ST_HOLD;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            first_q <= 4'h0;
            last_q  <= 3'h0;
        end else if (load_w) begin
            first_q <= first_pre_w;
            last_q  <= last_pre_w;
        end else if (count_en) begin
            first_q <= (first_q == 4'h0) ? top_w : first_q - 4'h1;
            if (dec_en[DECADES]) begin
                last_q <= last_q - 3'h1;
            end
        end
    end

    // a pulse due one cycle, or outside divide-by-2 two cycles, after hold starts is still sent
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            due_q <= 1'b0;
        end else begin
            due_q <= run_w && hold_w && upper_zero && (first_q == 4'h2);
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            out_q <= 1'b0;
        end else begin
            out_q <= pulse_w || (latch_w && out_q);
        end
    end

    assign div_out_o = out_q;
    assign status_w  = {9'h000, last_q, dec_q[2], dec_q[1], dec_q[0], first_q,
                        2'h0, (state_q == ST_RUN), out_q};

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);

    // reset may lift on the edge that samples hold; gate on sampled reset
    a_hold_loads: assert property (rstn_i && hold_w |=> (first_q == $past(first_pre_w))
        && (dec_q[0] == $past(preset_q[7:4])) && (last_q == $past(last_pre_w)))
        else $error("hold did not load presets");
    a_exit_arms: assert property ((state_q == ST_HOLD) && !hold_w |=> (state_q == ST_ARM))
        else $error("leaving hold did not arm");
    a_arm_still: assert property ((state_q == ST_ARM) && !hold_w
        |=> $stable(first_q) && $stable(last_q) && (state_q == ST_RUN))
        else $error("counter moved on arming edge");
    a_first_wrap: assert property (count_en && (first_q == 4'h0)
        |=> (first_q == $past(top_w)))
        else $error("first section wrap wrong");
    a_decade_step: assert property (dec_en[0] && !dec_zero[0]
        |=> (dec_q[0] == $past(dec_q[0]) - 4'h1))
        else $error("decade did not step on wrap");
    // borrow out of an empty decade reloads nine, whatever the preset was
    a_decade_wrap: assert property (dec_en[0] && dec_zero[0]
        |=> (dec_q[0] == BCD_TOP))
        else $error("decade did not wrap to nine");
    // borrow out of the top decade walks the last section
    a_last_step: assert property (dec_en[DECADES]
        |=> (last_q == $past(last_q) - 3'h1))
        else $error("last section did not step");
    a_term_pulse: assert property (term_w && !hold_w
        |=> out_q && (first_q == $past(first_pre_w)))
        else $error("terminal count missed reload or pulse");
    a_pulse_sets: assert property (pulse_w |=> out_q)
        else $error("pulse did not reach output");
    a_due_pulse: assert property (run_w && hold_w && upper_zero && (first_q == 4'h2)
        |=> ##1 out_q)
        else $error("pulse due during hold lost");
    a_latch_keep: assert property (latch_w && out_q |=> out_q)
        else $error("latched output dropped");
    a_single_width: assert property (!latch_w && out_q && !pulse_w |=> !out_q)
        else $error("output wider than one cycle");
    // wrap reload checked against the fixed value four, not the decode function
    a_div5_top: assert property ((mode_sel == MODE_DIV5) && count_en
        && (first_q == 4'h0) |=> (first_q == 4'h4))
        else $error("divide-by-5 decode wrong");

    // main scenarios
    c_pulse: cover property (term_w ##1 out_q);
    c_hold_exit: cover property ((state_q == ST_HOLD) ##1 (state_q == ST_ARM) ##1 run_w);
    c_latched: cover property (latch_w && out_q [*3]);
    c_due: cover property (due_q);
    c_last_borrow: cover property (dec_en[DECADES]);

endmodule : prog_div_counter

/* verilog/prog_div_pkg.sv */
// constants shared by the divide-by-n counter and its register slave
package prog_div_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [3:0]  CTRL_OFS      = 4'h0;
    localparam logic [3:0]  PRESET_OFS    = 4'h4;
    localparam logic [3:0]  STATUS_OFS    = 4'h8;
    localparam int          ADDR_W        = 4;

    // ------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------
    localparam int          CTRL_MODE_LSB = 0;
    localparam int          CTRL_HOLD_LO  = 3;
    localparam int          CTRL_HOLD_HI  = 4;
    localparam int          CTRL_LATCH    = 5;
    localparam int          CTRL_W        = 6;
    localparam logic [5:0]  CTRL_RST      = 6'h06;
    localparam logic [15:0] PRESET_RST    = 16'h0003;

    // ------------------------------------------------------------
    // status fields
    // ------------------------------------------------------------
    localparam int          ST_OUT_BIT    = 0;
    localparam int          ST_RUN_BIT    = 1;
    localparam int          ST_FIRST_LSB  = 4;
    localparam int          ST_DEC_LSB    = 8;
    localparam int          ST_LAST_LSB   = 20;

    // ------------------------------------------------------------
    // mode select codes {a,b,c}
    // ------------------------------------------------------------
    localparam logic [2:0]  MODE_DIV2     = 3'h7;
    localparam logic [2:0]  MODE_DIV4     = 3'h3;
    localparam logic [2:0]  MODE_DIV5     = 3'h5;
    localparam logic [2:0]  MODE_DIV8     = 3'h1;
    localparam logic [2:0]  MODE_DIV10    = 3'h6;

    localparam logic [3:0]  BCD_TOP       = 4'h9;
    localparam int          DECADES       = 3;

    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    typedef enum logic [2:0] {
        ST_HOLD = 3'b001,
        ST_ARM  = 3'b010,
        ST_RUN  = 3'b100
    } run_state_t;

endpackage : prog_div_pkg

/* verilog/prog_div_decade.sv */
// one presettable down-counting decade of the intermediate section
`timescale 1ns/10ps
module prog_div_decade
    import prog_div_pkg::*;
(
    input  wire logic       mclk_i,
    input  wire logic       rstn_i,
    input  wire logic       load_i,
    input  wire logic [3:0] preset_i,
    input  wire logic       dec_i,
    output logic      [3:0] q_o,
    output logic            zero_o
);
    logic [3:0] q_d;

    // binary preset up to 15 counts down, then wraps into bcd range
    assign zero_o = (q_o == 4'h0);
    assign q_d    = load_i ? preset_i :
                    !dec_i ? q_o :
                    zero_o ? BCD_TOP : q_o - 4'h1;

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            q_o <= 4'h0;
        end else begin
            q_o <= q_d;
        end
    end

endmodule : prog_div_decade

/* verilog/prog_div_axil.sv */
// axi4-lite slave front end: handshakes, write strobe, read capture
`timescale 1ns/10ps
module prog_div_axil
    import prog_div_pkg::*;
(
    input  wire logic              mclk_i,
    input  wire logic              rstn_i,
    input  wire logic [ADDR_W-1:0] awaddr_i,
    input  wire logic              awvalid_i,
    output logic                   awready_o,
    input  wire logic [31:0]       wdata_i,
    input  wire logic [3:0]        wstrb_i,
    input  wire logic              wvalid_i,
    output logic                   wready_o,
    output logic [1:0]             bresp_o,
    output logic                   bvalid_o,
    input  wire logic              bready_i,
    input  wire logic [ADDR_W-1:0] araddr_i,
    input  wire logic              arvalid_i,
    output logic                   arready_o,
    output logic [31:0]            rdata_o,
    output logic [1:0]             rresp_o,
    output logic                   rvalid_o,
    input  wire logic              rready_i,
    output logic                   wr_en_o,
    output logic [ADDR_W-1:0]      wr_addr_o,
    output logic [31:0]            wr_data_o,
    output logic [3:0]             wr_strb_o,
    input  wire logic              wr_ok_i,
    output logic [ADDR_W-1:0]      rd_addr_o,
    input  wire logic [31:0]       rd_data_i,
    input  wire logic              rd_ok_i
);
    logic aw_full_q;
    logic w_full_q;
    logic aw_take;
    logic w_take;
    logic ar_take;
    logic aw_full_d;
    logic w_full_d;
    logic bvalid_d;
    logic rvalid_d;

    assign aw_take   = awvalid_i && awready_o;
    assign w_take    = wvalid_i && wready_o;
    assign ar_take   = arvalid_i && arready_o;
    assign wr_en_o   = aw_full_q && w_full_q;
    assign rd_addr_o = araddr_i;

    // readies come from flops, fed from the next handshake state
    assign aw_full_d = !wr_en_o && (aw_full_q || aw_take);
    assign w_full_d  = !wr_en_o && (w_full_q || w_take);
    assign bvalid_d  = wr_en_o || (bvalid_o && !bready_i);
    assign rvalid_d  = ar_take || (rvalid_o && !rready_i);

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            awready_o <= 1'b1;
            wready_o  <= 1'b1;
            arready_o <= 1'b1;
        end else begin
            awready_o <= !aw_full_d && !bvalid_d;
            wready_o  <= !w_full_d && !bvalid_d;
            arready_o <= !rvalid_d;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            wr_addr_o <= '0;
            wr_data_o <= 32'h0000_0000;
            wr_strb_o <= 4'h0;
            bvalid_o  <= 1'b0;
            bresp_o   <= RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_full_q <= 1'b1;
                wr_addr_o <= awaddr_i;
            end
            if (w_take) begin
                w_full_q  <= 1'b1;
                wr_data_o <= wdata_i;
                wr_strb_o <= wstrb_i;
            end
            if (wr_en_o) begin
                aw_full_q <= 1'b0;
                w_full_q  <= 1'b0;
                bvalid_o  <= 1'b1;
                bresp_o   <= wr_ok_i ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_o && bready_i) begin
                bvalid_o  <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rvalid_o <= 1'b0;
            rdata_o  <= 32'h0000_0000;
            rresp_o  <= RESP_OKAY;
        end else if (ar_take) begin
            rvalid_o <= 1'b1;
            rdata_o  <= rd_ok_i ? rd_data_i : 32'h0000_0000;
            rresp_o  <= rd_ok_i ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_o && rready_i) begin
            rvalid_o <= 1'b0;
        end
    end

endmodule : prog_div_axil

/* verification/div_loop_model.sv */
// loop-side model: measures output pulse spacing and width
`timescale 1ns/10ps
module div_loop_model (
    input  wire logic mclk_i,
    input  wire logic rstn_i,
    input  wire logic div_i,
    output int        period_o,
    output int        width_o,
    output int        pulses_o
);
    int   gap_q;
    int   high_q;
    logic prev_q;
    wire  hi = (div_i === 1'b1);
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            gap_q    <= 0;
            high_q   <= 0;
            prev_q   <= 1'b0;
            period_o <= 0;
            width_o  <= 0;
            pulses_o <= 0;
        end else begin
            prev_q <= hi;
            gap_q  <= gap_q + 1;
            if (hi) high_q <= high_q + 1;
            if (hi && !prev_q) begin
                period_o <= gap_q + 1;
                gap_q    <= 0;
                high_q   <= 1;
                pulses_o <= pulses_o + 1;
            end
            if (!hi && prev_q) width_o <= high_q;
        end
    end
endmodule : div_loop_model

/* verification/tb_prog_div_counter.sv */
// testbench: register-driven divide-by-n scenarios
`timescale 1ns/10ps
module tb_prog_div_counter;
    import prog_div_pkg::*;
    logic mclk_i, rstn_i, awvalid, wvalid, bready, arvalid, rready;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata_o, d;
    logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, div_out_o;
    logic [1:0] bresp_o, rresp_o, r;
    int fails, checks, period, width, pulses, s;
    logic [2:0] md [6] = '{MODE_DIV10, MODE_DIV10, MODE_DIV8, MODE_DIV4, MODE_DIV5, MODE_DIV2};
    logic [15:0] ps [6] = '{16'h0047, 16'h00c3, 16'h0025, 16'h0023, 16'h0024, 16'h0013};
    int nn [6] = '{47, 123, 21, 11, 14, 2003};

    prog_div_counter u_dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .awaddr_i(awaddr),
        .awvalid_i(awvalid), .awready_o(awready_o), .wdata_i(wdata), .wstrb_i(wstrb),
        .wvalid_i(wvalid), .wready_o(wready_o), .bresp_o(bresp_o), .bvalid_o(bvalid_o),
        .bready_i(bready), .araddr_i(araddr), .arvalid_i(arvalid), .arready_o(arready_o),
        .rdata_o(rdata_o), .rresp_o(rresp_o), .rvalid_o(rvalid_o), .rready_i(rready),
        .div_out_o(div_out_o));
    div_loop_model u_loop (.mclk_i(mclk_i), .rstn_i(rstn_i), .div_i(div_out_o),
        .period_o(period), .width_o(width), .pulses_o(pulses));

    // ------------------------------------------------------------
    // clock and shared tasks
    // ------------------------------------------------------------
    initial begin
        mclk_i = 1'b0;
        forever #12.5 mclk_i = ~mclk_i;
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
        int n;
        logic done;
        n = 0;
        @(posedge mclk_i);
        awaddr  <= a;
        wdata   <= v;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge mclk_i);
            n++;
            if (awvalid && awready_o) awvalid <= 1'b0;
            if (wvalid && wready_o) wvalid <= 1'b0;
            done = (bvalid_o === 1'b1);
        end while (!done && n < 200);
        rs = bresp_o;
        bready <= 1'b0;
        if (!done) fails++;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
        int n;
        logic done;
        n = 0;
        @(posedge mclk_i);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge mclk_i);
            n++;
            if (arvalid && arready_o) arvalid <= 1'b0;
            done = (rvalid_o === 1'b1);
        end while (!done && n < 200);
        v = rdata_o;
        rs = rresp_o;
        rready <= 1'b0;
        if (!done) fails++;
    endtask : rd

    task automatic wait_pulses(input int k);
        int n;
        n = 0;
        s = pulses;
        while (pulses < s + k && n < 9000) begin
            @(posedge mclk_i);
            n++;
        end
        if (n >= 9000) fails++;
    endtask : wait_pulses

    task automatic tally_and_finish;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : tally_and_finish

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        {rstn_i, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hf;
        repeat (12) @(posedge mclk_i);
        rstn_i <= 1'b1;
        rd(CTRL_OFS, d, r);
        chk("ctrl reset", d, {26'h0, CTRL_RST});
        rd(PRESET_OFS, d, r);
        chk("preset reset", d, {16'h0, PRESET_RST});
        rd(4'hc, d, r);
        chk("unmapped rdata", d, 32'h0000_0000);
        chk("unmapped rresp", {30'h0, r}, {30'h0, RESP_SLVERR});
        wr(4'hc, 32'h0000_0001, r);
        chk("unmapped bresp", {30'h0, r}, {30'h0, RESP_SLVERR});
        rd(STATUS_OFS, d, r);
        chk("idle in hold", {31'h0, d[ST_RUN_BIT]}, 32'h0000_0000);
        chk("first in hold", {28'h0, d[ST_FIRST_LSB +: 4]}, {28'h0, PRESET_RST[3:0]});
        for (int i = 0; i < 6; i++) begin
            wr(CTRL_OFS, {29'h0, md[i]}, r);
            chk("ctrl bresp", {30'h0, r}, {30'h0, RESP_OKAY});
            wr(PRESET_OFS, {16'h0, ps[i]}, r);
            repeat (3) @(posedge mclk_i);
            wr(CTRL_OFS, {26'h0, 3'h1, md[i]}, r);
            wait_pulses(3);
            chk("period", period, nn[i]);
            chk("width", width, 32'h0000_0001);
        end
        rd(STATUS_OFS, d, r);
        chk("running", {31'h0, d[ST_RUN_BIT]}, 32'h0000_0001);
        wr(CTRL_OFS, {26'h0, 3'h5, MODE_DIV4}, r);
        wait_pulses(1);
        repeat (5) @(posedge mclk_i);
        chk("latched high", {31'h0, div_out_o}, 32'h0000_0001);
        wr(CTRL_OFS, {26'h0, 3'h1, MODE_DIV4}, r);
        repeat (2) @(posedge mclk_i);
        chk("latch released", {31'h0, div_out_o}, 32'h0000_0000);
        wr(CTRL_OFS, {29'h0, MODE_DIV4}, r);
        s = pulses;
        repeat (200) @(posedge mclk_i);
        chk("frozen", pulses, s);
        tally_and_finish();
    end

    initial begin
        repeat (60000) @(posedge mclk_i);
        fails++;
        tally_and_finish();
    end
endmodule : tb_prog_div_counter
